/* File: src/lvs_lanes.sv */
/*
  lvs_lanes: one transmit and one receive serdes lane with clock-crossing
  fifos between the core clock and the bit-rate clock.
  assumes: bit_rate_clock comes from the dedicated lane pll; pads are
  differential buffers outside this logic; configuration is static.
*/
`default_nettype none

// ----------------------------------------------------------------
// dual-clock fifo, gray pointers
// ----------------------------------------------------------------
module lvs_afifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
) (
  input  wire logic         wr_clk,
  input  wire logic         wr_rst,
  input  wire logic         wr_valid,
  output logic              wr_ready,
  input  wire logic [W-1:0] wr_data,
  input  wire logic         rd_clk,
  input  wire logic         rd_rst,
  output logic              rd_valid,
  input  wire logic         rd_ready,
  output logic [W-1:0]      rd_data
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wbin_reg;
  logic [AW:0]  rbin_reg;
  logic [AW:0]  wgray_reg;
  logic [AW:0]  rgray_reg;
  logic [AW:0]  rg_s1_reg;
  logic [AW:0]  rg_s2_reg;
  logic [AW:0]  wg_s1_reg;
  logic [AW:0]  wg_s2_reg;
  logic [AW:0]  wbin_next;
  logic [AW:0]  rbin_next;
  logic         push;
  logic         pop;

  assign push      = wr_valid && wr_ready;
  assign pop       = rd_valid && rd_ready;
  assign wbin_next = wbin_reg + {{AW{1'b0}}, push};
  assign rbin_next = rbin_reg + {{AW{1'b0}}, pop};
  assign wr_ready  = wgray_reg != {~rg_s2_reg[AW:AW-1], rg_s2_reg[AW-2:0]};
  assign rd_valid  = rgray_reg != wg_s2_reg;
  assign rd_data   = mem[rbin_reg[AW-1:0]];

  always_ff @(posedge wr_clk) begin
    if (push) begin
      mem[wbin_reg[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge wr_clk) begin
    if (wr_rst) begin
      wbin_reg  <= '0;
      wgray_reg <= '0;
      rg_s1_reg <= '0;
      rg_s2_reg <= '0;
    end else begin
      wbin_reg  <= wbin_next;
      wgray_reg <= wbin_next ^ (wbin_next >> 1);
      rg_s1_reg <= rgray_reg;
      rg_s2_reg <= rg_s1_reg;
    end
  end

  always_ff @(posedge rd_clk) begin
    if (rd_rst) begin
      rbin_reg  <= '0;
      rgray_reg <= '0;
      wg_s1_reg <= '0;
      wg_s2_reg <= '0;
    end else begin
      rbin_reg  <= rbin_next;
      rgray_reg <= rbin_next ^ (rbin_next >> 1);
      wg_s1_reg <= wgray_reg;
      wg_s2_reg <= wg_s1_reg;
    end
  end
endmodule // lvs_afifo

// ----------------------------------------------------------------
// lane top
// ----------------------------------------------------------------
module lvs_lanes (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic                        bit_rate_clock,
  input  wire lvs_pkg::lvs_cfg_t           tx_cfg,
  input  wire lvs_pkg::lvs_cfg_t           rx_cfg,
  input  wire logic                        rx_rst,
  input  wire logic [lvs_pkg::WORD_W-1:0]  tx_data,
  input  wire logic                        tx_valid,
  output logic                             tx_ready,
  output logic [lvs_pkg::WORD_W-1:0]       rx_data,
  output logic                             rx_valid,
  input  wire logic                        rx_ready,
  output logic                             tx_pad_data,
  output logic                             tx_pad_clk,
  output logic                             tx_word_rate_clock,
  input  wire logic                        rx_pad_data,
  output logic                             rx_word_rate_clock,
  output logic                             bypass_side_input,
  output logic                             pll_reference_connection,
  output logic                             pll_feedback_connection
);
  import lvs_pkg::*;

  // next position in a word of f bits, wrapping at the boundary
  function automatic logic [3:0] lvs_cnt_step(input logic [3:0] c, input lvs_fac_t f);
    logic [3:0] n;
    n = c + CNT_ONE;
    if (n >= f) begin
      n = CNT_ZERO;
    end
    return n;
  endfunction

  // word clock high over the first half of the word
  function automatic logic lvs_wclk_high(input logic [3:0] c, input lvs_fac_t f);
    logic h;
    h = c < ((f + CNT_ONE) >> 1);
    return h;
  endfunction

  // ----------------------------------------------------------------
  // reset and configuration into the bit domain
  // ----------------------------------------------------------------
  logic     rst_s1_reg;
  logic     rst_bit_reg;
  logic     rxr_s1_reg;
  logic     rxr_s2_reg;
  lvs_cfg_t txc_s1_reg;
  lvs_cfg_t txc_s2_reg;
  lvs_cfg_t rxc_s1_reg;
  lvs_cfg_t rxc_s2_reg;
  lvs_fac_t tx_fac;
  lvs_fac_t rx_fac;

  always_ff @(posedge bit_rate_clock) begin
    rst_s1_reg  <= rst;
    rst_bit_reg <= rst_s1_reg;
    rxr_s1_reg  <= rx_rst;
    rxr_s2_reg  <= rxr_s1_reg;
  end

  always_ff @(posedge bit_rate_clock) begin
    txc_s1_reg <= tx_cfg;
    txc_s2_reg <= txc_s1_reg;
    rxc_s1_reg <= rx_cfg;
    rxc_s2_reg <= rxc_s1_reg;
  end

  assign tx_fac = lvs_fac_norm(txc_s2_reg.fac);
  assign rx_fac = lvs_fac_norm(rxc_s2_reg.fac);

  // ----------------------------------------------------------------
  // transmit path: core -> fifo -> serializer
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] txf_data;
  logic              txf_valid;
  logic              txf_ready;
  logic [3:0]        tx_cnt_reg;
  logic [3:0]        tx_cnt_next;
  logic [WORD_W-1:0] tx_sh_reg;
  logic              tx_fwd_reg;
  logic              tx_wclk_reg;

  lvs_afifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_tx_fifo (
    .wr_clk   (core_clk),
    .wr_rst   (rst),
    .wr_valid (tx_valid),
    .wr_ready (tx_ready),
    .wr_data  (tx_data),
    .rd_clk   (bit_rate_clock),
    .rd_rst   (rst_bit_reg),
    .rd_valid (txf_valid),
    .rd_ready (txf_ready),
    .rd_data  (txf_data)
  );

  // a new word is taken only at a word boundary
  assign txf_ready   = (tx_cnt_reg == CNT_ZERO) && !rst_bit_reg;
  assign tx_cnt_next = lvs_cnt_step(tx_cnt_reg, tx_fac);

  always_ff @(posedge bit_rate_clock) begin
    if (rst_bit_reg) begin
      tx_cnt_reg <= CNT_ZERO;
    end else begin
      tx_cnt_reg <= tx_cnt_next;
    end
  end

  // left-justify the low fac bits, shift out msb first
  always_ff @(posedge bit_rate_clock) begin
    if (rst_bit_reg) begin
      tx_sh_reg <= WORD_ZERO;
    end else if (txf_ready) begin
      tx_sh_reg <= txf_valid ? (txf_data << (FAC_MAX - tx_fac))
                             : WORD_ZERO;
    end else begin
      tx_sh_reg <= tx_sh_reg << 1;
    end
  end

  // forwarded clock toggles with every bit: edges sit on data edges
  always_ff @(posedge bit_rate_clock) begin
    if (rst_bit_reg) begin
      tx_fwd_reg <= 1'b0;
    end else begin
      tx_fwd_reg <= ~tx_fwd_reg;
    end
  end

  always_ff @(posedge bit_rate_clock) begin
    if (rst_bit_reg) begin
      tx_wclk_reg <= 1'b0;
    end else begin
      tx_wclk_reg <= lvs_wclk_high(tx_cnt_next, tx_fac);
    end
  end

  assign tx_pad_data        = tx_sh_reg[MSB];
  assign tx_pad_clk         = tx_fwd_reg;
  assign tx_word_rate_clock = tx_wclk_reg;

  // ----------------------------------------------------------------
  // receive path: pad -> deserializer -> fifo -> core
  // ----------------------------------------------------------------
  logic              rx_s1_reg;
  logic              rx_s2_reg;
  logic              rx_clr;
  logic              rx_alt;
  logic [3:0]        rx_cnt_reg;
  logic [3:0]        rx_cnt_next;
  logic [WORD_W-1:0] rx_sh_reg;
  logic [WORD_W-1:0] rx_sh_next;
  logic [WORD_W-1:0] rx_word_reg;
  logic              rx_push_reg;
  logic              rxf_ready;
  logic              rx_wclk_reg;
  logic              pll_ref_reg;
  logic              pll_fbk_reg;

  // pad bit enters through two flops, single edge only
  always_ff @(posedge bit_rate_clock) begin
    rx_s1_reg <= rx_pad_data;
    rx_s2_reg <= rx_s1_reg;
  end

  assign rx_clr      = rst_bit_reg || rxr_s2_reg;
  assign rx_alt      = (rx_fac == FAC_BYPASS) && rxc_s2_reg.alt_en;
  assign rx_sh_next  = {rx_sh_reg[MSB-1:0], rx_s2_reg};
  assign rx_cnt_next = lvs_cnt_step(rx_cnt_reg, rx_fac);

  always_ff @(posedge bit_rate_clock) begin
    if (rx_clr) begin
      rx_cnt_reg <= CNT_ZERO;
      rx_sh_reg  <= WORD_ZERO;
    end else begin
      rx_cnt_reg <= rx_cnt_next;
      rx_sh_reg  <= rx_sh_next;
    end
  end

  // the word closes when the count wraps; upper bits read zero
  always_ff @(posedge bit_rate_clock) begin
    if (rx_clr) begin
      rx_push_reg <= 1'b0;
      rx_word_reg <= WORD_ZERO;
    end else begin
      rx_push_reg <= (rx_cnt_next == CNT_ZERO) && !rx_alt;
      if (rx_cnt_next == CNT_ZERO) begin
        rx_word_reg <= rx_sh_next & lvs_mask(rx_fac);
      end
    end
  end

  always_ff @(posedge bit_rate_clock) begin
    if (rx_clr) begin
      rx_wclk_reg <= 1'b0;
    end else begin
      rx_wclk_reg <= lvs_wclk_high(rx_cnt_next, rx_fac);
    end
  end

  // bypass bit steered to the pll instead of the core
  always_ff @(posedge bit_rate_clock) begin
    if (rst_bit_reg) begin
      pll_ref_reg <= 1'b0;
      pll_fbk_reg <= 1'b0;
    end else begin
      pll_ref_reg <= rx_alt && !rxc_s2_reg.alt_fbk && rx_s2_reg;
      pll_fbk_reg <= rx_alt &&  rxc_s2_reg.alt_fbk && rx_s2_reg;
    end
  end

  // a word that finds the fifo full is dropped, serial data cannot wait
  lvs_afifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_rx_fifo (
    .wr_clk   (bit_rate_clock),
    .wr_rst   (rst_bit_reg),
    .wr_valid (rx_push_reg),
    .wr_ready (rxf_ready),
    .wr_data  (rx_word_reg),
    .rd_clk   (core_clk),
    .rd_rst   (rst),
    .rd_valid (rx_valid),
    .rd_ready (rx_ready),
    .rd_data  (rx_data)
  );

  assign rx_word_rate_clock       = rx_wclk_reg;
  assign bypass_side_input        = pll_ref_reg || pll_fbk_reg;
  assign pll_reference_connection = pll_ref_reg;
  assign pll_feedback_connection  = pll_fbk_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_tx_load_word: assert property (@(posedge bit_rate_clock) disable iff (rst_bit_reg)
    txf_ready && txf_valid |=> tx_sh_reg == ($past(txf_data) << (FAC_MAX - $past(tx_fac))))
    else $error("tx word not loaded at boundary");

  a_tx_shift_msb: assert property (@(posedge bit_rate_clock) disable iff (rst_bit_reg)
    !txf_ready ##1 !$past(txf_ready) |-> tx_pad_data == $past(tx_sh_reg[MSB-1]))
    else $error("tx bit order broken");

  a_tx_cnt_bound: assert property (@(posedge bit_rate_clock) disable iff (rst_bit_reg)
    tx_cnt_reg < tx_fac)
    else $error("tx count beyond factor");

  a_fwd_clk_edge: assert property (@(posedge bit_rate_clock) disable iff (rst_bit_reg)
    $past(!rst_bit_reg) |-> tx_pad_clk != $past(tx_pad_clk))
    else $error("forwarded clock missed a bit edge");

  a_rx_word_width: assert property (@(posedge bit_rate_clock) disable iff (rx_clr)
    rx_push_reg |-> (rx_word_reg & ~lvs_mask(rx_fac)) == WORD_ZERO)
    else $error("rx word wider than factor");

  a_rx_push_rate: assert property (@(posedge bit_rate_clock) disable iff (rx_clr)
    rx_push_reg && rx_fac == FAC_MAX && !rx_alt |=> !rx_push_reg [*7] ##1 rx_push_reg)
    else $error("rx words not one per eight bits");

  a_rx_reset_clr: assert property (@(posedge bit_rate_clock) disable iff (rst_bit_reg)
    rxr_s2_reg |=> rx_cnt_reg == CNT_ZERO && !rx_push_reg && rx_sh_reg == WORD_ZERO)
    else $error("rx reset did not clear deserializer");

  a_alt_no_core: assert property (@(posedge bit_rate_clock) disable iff (rx_clr)
    rx_alt |=> !rx_push_reg && pll_reference_connection == (!$past(rxc_s2_reg.alt_fbk)
                                                          && $past(rx_s2_reg)))
    else $error("bypass bit not steered to pll");

  a_rx_shift_in: assert property (@(posedge bit_rate_clock) disable iff (rx_clr)
    $past(!rx_clr) |-> rx_sh_reg[0] == $past(rx_s2_reg))
    else $error("rx shift lost a bit");
endmodule // lvs_lanes
`default_nettype wire

/* File: src/lvs_pkg.sv */
/*
  lvs_pkg: shared constants and carrier types for the serdes lanes.
  assumes: a 20 MHz core clock and a separate bit-rate clock from the pll.
*/
`default_nettype none
package lvs_pkg;
  localparam int unsigned WORD_W     = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned FAC_W      = 4;
  localparam logic [3:0]  FAC_MAX    = 4'h8;
  localparam logic [3:0]  FAC_BYPASS = 4'h1;
  localparam logic [3:0]  CNT_ZERO   = 4'h0;
  localparam logic [3:0]  CNT_ONE    = 4'h1;
  localparam logic [7:0]  WORD_ZERO  = 8'h00;
  localparam logic [7:0]  WORD_ONES  = 8'hff;
  localparam int unsigned MSB        = WORD_W - 1;
  localparam int unsigned CORE_PERIOD_NS = 50;
  localparam int unsigned MAX_RATE_MBPS  = 800;

  typedef logic [FAC_W-1:0] lvs_fac_t;

  typedef struct packed {
    lvs_fac_t fac;      // bits per word, 1 means bypass
    logic     alt_en;   // rx only: bypass bit goes to the pll
    logic     alt_fbk;  // rx only: feedback instead of reference
  } lvs_cfg_t;

  // out-of-range factors fall back to the widest word
  function automatic lvs_fac_t lvs_fac_norm(input lvs_fac_t f);
    lvs_fac_t r;
    r = f;
    if (f == CNT_ZERO || f > FAC_MAX) begin
      r = FAC_MAX;
    end
    return r;
  endfunction

  // keep only the low f bits of a word
  function automatic logic [WORD_W-1:0] lvs_mask(input lvs_fac_t f);
    logic [WORD_W-1:0] m;
    m = WORD_ONES >> (FAC_MAX - f);
    return m;
  endfunction
endpackage
`default_nettype wire

/* File: verification/lvs_peer_model.sv */
/*
  lvs_peer_model: board-side lvds partner, receives tx bits, sends rx bits.
  assumes: bit_rate_clock is the forwarded link clock; idle line is low.
*/
`default_nettype none
module lvs_peer_model (
  input  wire logic bit_rate_clock,
  input  wire logic tx_pad_data,
  input  wire logic tx_pad_clk,
  output logic      rx_pad_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cap_bits [0:127];
  int   ncap;
  int   clk_errs;
  logic seen;
  logic clk_prev;

  initial begin
    rx_pad_data = 1'b0;
    clear();
  end

  task automatic clear();
    ncap = 0;
    clk_errs = 0;
    seen = 1'b0;
    clk_prev = 1'b0;
    foreach (cap_bits[i]) cap_bits[i] = 1'bx;
  endtask

  // ----------------------------------------------------------------
  // capture mid-bit, skipping idle zeros
  // ----------------------------------------------------------------
  always @(negedge bit_rate_clock) begin
    if (seen && tx_pad_clk === clk_prev) clk_errs++;
    clk_prev = tx_pad_clk;
    if ((seen || tx_pad_data === 1'b1) && ncap < 128) begin
      cap_bits[ncap] = tx_pad_data;
      ncap++;
      seen = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // send msb first, one bit per link clock
  // ----------------------------------------------------------------
  task automatic send(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge bit_rate_clock);
      rx_pad_data = v[i];
    end
    @(negedge bit_rate_clock);
    rx_pad_data = 1'b0;
  endtask
endmodule // lvs_peer_model
`default_nettype wire

/* File: verification/tb.sv */
/*
  tb: self-checking bench of lvs_lanes with a board-side partner.
  assumes: 20 MHz core clock, 8 MHz link clock, static configuration.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lvs_pkg::*;
  logic       core_clk, rst, bit_rate_clock, rx_rst, tx_valid, tx_ready;
  logic       rx_valid, rx_ready, tx_pad_data, tx_pad_clk, rx_pad_data;
  logic       pll_ref, pll_fbk, bsi, full_seen, tx_wclk, rx_wclk;
  lvs_cfg_t   tx_cfg, rx_cfg;
  logic [7:0] tx_data, rx_data;
  int         miscompares, num_checks;

  lvs_lanes dut_u (.core_clk(core_clk), .rst(rst), .bit_rate_clock(bit_rate_clock),
    .tx_cfg(tx_cfg), .rx_cfg(rx_cfg), .rx_rst(rx_rst), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .tx_pad_data(tx_pad_data), .tx_pad_clk(tx_pad_clk),
    .tx_word_rate_clock(tx_wclk), .rx_pad_data(rx_pad_data), .rx_word_rate_clock(rx_wclk),
    .bypass_side_input(bsi), .pll_reference_connection(pll_ref),
    .pll_feedback_connection(pll_fbk));
  lvs_peer_model peer_u (.bit_rate_clock(bit_rate_clock), .tx_pad_data(tx_pad_data),
    .tx_pad_clk(tx_pad_clk), .rx_pad_data(rx_pad_data));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    bit_rate_clock = 1'b0;
    #37;
    forever #62.5 bit_rate_clock = ~bit_rate_clock;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input lvs_cfg_t tc, input lvs_cfg_t rc);
    @(posedge core_clk);
    #2;
    tx_cfg = tc;
    rx_cfg = rc;
    rst = 1'b1;
    repeat (12) @(posedge core_clk);
    #2 rst = 1'b0;
    repeat (10) @(posedge core_clk);
    peer_u.clear();
    #2;
  endtask

  task automatic push(input logic [7:0] w);
    int n;
    tx_data = w;
    tx_valid = 1'b1;
    n = 0;
    @(posedge core_clk);
    while (tx_ready !== 1'b1 && n < 2000) begin
      full_seen = 1'b1;
      n++;
      @(posedge core_clk);
    end
    if (n >= 2000) miscompares++;
    #2;
  endtask

  // bit clocks between two rising edges of a word clock
  task automatic chk_wclk(input logic [3:0] eff, input logic rx_side);
    logic prev, cur;
    int   n, e;
    prev = 1'b1;
    n = 0;
    e = 0;
    for (int k = 0; k < 40 && e < 2; k++) begin
      @(negedge bit_rate_clock);
      cur = rx_side ? rx_wclk : tx_wclk;
      if (e == 1) n++;
      if (cur === 1'b1 && prev === 1'b0) e++;
      prev = cur;
    end
    chk(128'(n), 128'(eff));
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_tx(input logic [3:0] f);
    logic [3:0]   eff;
    logic [7:0]   w;
    logic [127:0] exp, got;
    int           nw, nb, t;
    eff = (f == 4'h0) ? 4'h8 : f;
    nw = (eff == 4'h8) ? 10 : 3;
    do_reset('{fac: f, alt_en: 1'b0, alt_fbk: 1'b0}, '{fac: 4'h1, alt_en: 1'b0, alt_fbk: 1'b0});
    full_seen = 1'b0;
    nb = 0;
    exp = '0;
    for (int i = 0; i < nw; i++) begin
      w = 8'hb5 + 8'(i) * 8'h3b;
      if (i == 0) w[eff-1] = 1'b1;
      push(w);
      for (int b = int'(eff) - 1; b >= 0; b--) begin
        exp = {exp[126:0], w[b]};
        nb++;
      end
    end
    tx_valid = 1'b0;
    t = 0;
    while (peer_u.ncap < nb && t < 3000) begin
      @(posedge core_clk);
      t++;
    end
    got = '0;
    for (int i = 0; i < nb; i++) got = {got[126:0], peer_u.cap_bits[i]};
    chk(got, exp);
    chk(128'(peer_u.clk_errs), '0);
    if (eff > 4'h1) chk_wclk(eff, 1'b0);
    if (eff == 4'h8) chk(128'(full_seen), 128'h1);
  endtask

  task automatic test_rx();
    logic [127:0] got;
    logic         seen;
    int           nb, t;
    do_reset('{fac: 4'h8, alt_en: 1'b0, alt_fbk: 1'b0}, '{fac: 4'h1, alt_en: 1'b0, alt_fbk: 1'b0});
    rx_ready = 1'b1;
    got = '0;
    seen = 1'b0;
    nb = 0;
    t = 0;
    fork peer_u.send(16'hb38d, 16); join_none
    while (nb < 16 && t < 400) begin
      @(posedge core_clk);
      t++;
      if (rx_valid === 1'b1) begin
        chk(128'(rx_data[7:1]), '0);
        if (seen || rx_data[0] === 1'b1) begin
          got = {got[126:0], rx_data[0]};
          nb++;
          seen = 1'b1;
        end
      end
    end
    chk(got, 128'hb38d);
  endtask

  task automatic test_rx4();
    logic found;
    do_reset('{fac: 4'h8, alt_en: 1'b0, alt_fbk: 1'b0}, '{fac: 4'h4, alt_en: 1'b0, alt_fbk: 1'b0});
    found = 1'b0;
    fork peer_u.send(16'hffff, 16); join_none
    repeat (60) begin
      @(posedge core_clk);
      if (rx_valid === 1'b1) begin
        chk(128'(rx_data[7:4]), '0);
        if (rx_data === 8'h0f) found = 1'b1;
      end
    end
    chk_wclk(4'h4, 1'b1);
    chk(128'(found), 128'h1);
  endtask

  task automatic test_rxrst();
    logic bad, found;
    do_reset('{fac: 4'h8, alt_en: 1'b0, alt_fbk: 1'b0}, '{fac: 4'h4, alt_en: 1'b0, alt_fbk: 1'b0});
    bad = 1'b0;
    found = 1'b0;
    rx_ready = 1'b1;
    rx_rst = 1'b1;
    repeat (10) @(posedge core_clk);
    fork peer_u.send(16'hffff, 16); join_none
    repeat (50) begin
      @(posedge core_clk);
      if (rx_valid === 1'b1 && rx_data !== 8'h00) bad = 1'b1;
    end
    #2 rx_rst = 1'b0;
    fork peer_u.send(16'hffff, 16); join_none
    repeat (60) begin
      @(posedge core_clk);
      if (rx_valid === 1'b1 && rx_data === 8'h0f) found = 1'b1;
    end
    chk(128'(bad), '0);
    chk(128'(found), 128'h1);
  endtask

  task automatic test_alt(input logic fbk);
    do_reset('{fac: 4'h8, alt_en: 1'b0, alt_fbk: 1'b0}, '{fac: 4'h1, alt_en: 1'b1, alt_fbk: fbk});
    fork peer_u.send(16'hffff, 16); join_none
    repeat (20) @(posedge core_clk);
    chk(128'(pll_ref), 128'(!fbk));
    chk(128'(pll_fbk), 128'(fbk));
    chk(128'(bsi), 128'h1);
    chk(128'(rx_valid), '0);
    repeat (40) @(posedge core_clk);
    chk(128'({pll_ref, pll_fbk, bsi}), '0);
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    rx_rst = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    rx_ready = 1'b0;
    tx_cfg = '0;
    rx_cfg = '0;
    miscompares = 0;
    num_checks = 0;
    full_seen = 1'b0;
    for (int f = 0; f <= 8; f++) test_tx(4'(f));
    test_rx();
    test_rx4();
    test_rxrst();
    test_alt(1'b0);
    test_alt(1'b1);
    end_of_test();
  end

  initial begin
    #1000000;
    miscompares++;
    end_of_test();
  end
endmodule // tb
`default_nettype wire
